// *** tb/cmpev_assertions.sv ***
`timescale 1ns/1ps
module cmpev_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Controls
    input cmpev_pkg::cmpev_cfg_t cfg [cmpev_pkg::NUM_UNITS],
    input wire logic [cmpev_pkg::REF_CODE_W-1:0] ref_code,
    input wire logic [cmpev_pkg::NUM_UNITS-1:0] irq_enable,
    input wire logic [cmpev_pkg::NUM_UNITS-1:0] irq_clear,
    input wire logic select_masked_status,
    input wire logic [cmpev_pkg::NUM_UNITS-1:0] comp_raw,
    // Outputs watched
    input wire logic ref_enable,
    input wire logic [cmpev_pkg::NUM_UNITS-1:0] comp_value,
    input wire logic [cmpev_pkg::NUM_UNITS-1:0] irq_raw_status,
    input wire logic [cmpev_pkg::NUM_UNITS-1:0] irq_masked_status,
    input wire logic [cmpev_pkg::NUM_UNITS-1:0] irq_status_view,
    input wire logic irq_out,
    input wire logic [cmpev_pkg::NUM_UNITS-1:0] adc_trigger
);
    // One domain, so one clock and one reset for all
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_mask_gate: assert property (
        irq_masked_status == (irq_raw_status & irq_enable)) else $error("masked wrong");
    a_view_mux: assert property (
        irq_status_view == (select_masked_status ? irq_masked_status : irq_raw_status))
        else $error("status view wrong");
    a_irq_line: assert property (irq_out == |irq_masked_status) else $error("irq wrong");
    // A steady input must have crossed the three stages
    a_value_lag: assert property (
        $stable(comp_raw)[*4] |-> comp_value == comp_raw) else $error("value stale");
    a_trig_off: assert property (
        cfg[2].trig == cmpev_pkg::adc_trigger_off && $stable(cfg[2].trig) |-> !adc_trigger[2])
        else $error("trigger while off");
    a_rise_pulse: assert property (
        cfg[2].trig == cmpev_pkg::adc_trigger_on_rising && $stable(cfg[2].trig)
        && $rose(comp_value[2]) |-> adc_trigger[2] ##1 !adc_trigger[2]) else $error("no pulse");
    // A new edge at the clear edge may win, so it excuses the drop
    a_clear_drop: assert property (
        irq_clear[0] && cfg[0].irq == cmpev_pkg::irq_on_rising
        |=> !irq_raw_status[0] || $rose(comp_value[0])) else $error("clear ignored");
    a_ref_map: assert property (
        ref_enable == (ref_code != 5'h00 && ref_code <= cmpev_pkg::REF_CODE_MAX))
        else $error("reference enable wrong");
endmodule : cmpev_checker

// *** tb/cmpev_far_end.sv ***
`timescale 1ns/1ps
module cmpev_far_end #(
    parameter int N = 3
) (
    // Clock and reset
    clk,
    rst_b,
    // Interrupt side of the block
    irq_out,
    irq_raw_status,
    // Handler behaviour
    auto_clear,
    irq_clear
);
    input wire logic clk;
    input wire logic rst_b;
    input wire logic irq_out;
    input wire logic [N-1:0] irq_raw_status;
    input wire logic auto_clear;
    output logic [N-1:0] irq_clear;
    // Handler clears first thing, one pulse, then waits a cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_clear <= '0;
        end else begin
            irq_clear <= (auto_clear && irq_out && !(|irq_clear)) ? irq_raw_status : '0;
        end
    end
endmodule : cmpev_far_end

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
    localparam int N = cmpev_pkg::NUM_UNITS;
    // Stimulus
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    cmpev_pkg::cmpev_cfg_t cfg [N] = '{default: '0};
    logic [4:0] ref_code = 5'h00;
    logic [N-1:0] irq_en = '0, tb_clr = '0, raw = '0;
    logic sel_m = 1'b0;
    logic auto_clr = 1'b0;
    // Observed
    logic [N-1:0] clr, pin0, use_ref, pin, val, st_raw, st_m, st_v, trig;
    logic ref_en, irq;
    logic [4:0] lvl;
    int errors = 0;
    int n_compared = 0;
    always #2.5 clk = ~clk;
    cmpev_top u_cmpev_top (.clk(clk), .rst_b(rst_b), .cfg(cfg), .ref_code(ref_code),
        .irq_enable(irq_en), .irq_clear(tb_clr | clr), .select_masked_status(sel_m),
        .comp_raw(raw), .use_first_unit_positive_pin(pin0), .use_internal_reference(use_ref),
        .ref_enable(ref_en), .ref_level(lvl), .comp_pin_out(pin), .comp_value(val),
        .irq_raw_status(st_raw), .irq_masked_status(st_m), .irq_status_view(st_v),
        .irq_out(irq), .adc_trigger(trig));
    cmpev_far_end #(.N(N)) u_cmpev_far_end (.clk(clk), .rst_b(rst_b), .irq_out(irq),
        .irq_raw_status(st_raw), .auto_clear(auto_clr), .irq_clear(clr));
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish
    // Every code, both range ends and the unused top codes
    task automatic t_ref();
        for (int c = 0; c < 32; c++) begin
            ref_code = c[4:0];
            step(1);
            chk("ref_en", {7'h00, c >= 1 && c <= 28}, {7'h00, ref_en});
            if (c >= 1 && c <= 28) chk("ref_lvl", 8'(c - 1), {3'h0, lvl});
        end
        $display("test ref done");
    endtask : t_ref
    task automatic t_pos();
        for (int u = 0; u < N; u++) begin
            for (int s = 0; s < 3; s++) begin
                cfg[u].pos = cmpev_pkg::cmpev_pos_sel_t'(s);
                step(1);
                chk("pos_pin0", {7'h00, s == 1 && u != 0}, {7'h00, pin0[u]});
                chk("pos_ref", {7'h00, s == 2}, {7'h00, use_ref[u]});
            end
        end
        $display("test pos done");
    endtask : t_pos
    task automatic t_pin();
        for (int p = 0; p < 3; p++) begin
            cfg[1].pin = cmpev_pkg::cmpev_pin_sel_t'(p);
            raw[1] = 1'b1;
            step(4);
            chk("pin_hi", {7'h00, p != 1}, {7'h00, pin[1]});
            chk("val_hi", 8'h01, {7'h00, val[1]});
            raw[1] = 1'b0;
            step(4);
            chk("pin_lo", {7'h00, p == 1}, {7'h00, pin[1]});
            chk("val_lo", 8'h00, {7'h00, val[1]});
        end
        $display("test pin done");
    endtask : t_pin
    // Two samples after each edge: a pulse reads 10, a level 11
    task automatic t_trig();
        logic [1:0] er [6] = '{2'h0, 2'h3, 2'h0, 2'h0, 2'h2, 2'h2};
        logic [1:0] ef [6] = '{2'h0, 2'h0, 2'h3, 2'h2, 2'h0, 2'h2};
        logic [1:0] a;
        for (int m = 0; m < 6; m++) begin
            cfg[2].trig = cmpev_pkg::cmpev_trig_sel_t'(m);
            for (int d = 1; d >= 0; d--) begin
                raw[2] = d[0];
                step(4);
                a[1] = trig[2];
                step(1);
                a[0] = trig[2];
                chk("trig", {6'h00, d[0] ? er[m] : ef[m]}, {6'h00, a});
            end
        end
        $display("test trig done");
    endtask : t_trig
    // Pending after clear, after rise, after fall; level mode resists the clear
    task automatic t_irq();
        logic [2:0] e [5] = '{3'h2, 3'h5, 3'h1, 3'h3, 3'h3};
        logic [2:0] r;
        for (int m = 0; m < 5; m++) begin
            cfg[0].irq = cmpev_pkg::cmpev_irq_sel_t'(m);
            tb_clr[0] = 1'b1;
            step(1);
            tb_clr[0] = 1'b0;
            step(1);
            r[2] = st_raw[0];
            raw[0] = 1'b1;
            step(4);
            r[1] = st_raw[0];
            raw[0] = 1'b0;
            step(4);
            r[0] = st_raw[0];
            chk("irq_mode", {5'h00, e[m]}, {5'h00, r});
        end
        $display("test irq done");
    endtask : t_irq
    task automatic t_mask();
        irq_en[0] = 1'b1;
        raw[0] = 1'b1;
        step(4);
        chk("irq_on", 8'h01, {7'h00, irq});
        irq_en[0] = 1'b0;
        sel_m = 1'b1;
        step(1);
        // Order: view, masked, line, raw; enable off leaves only raw set
        chk("masked", 8'h01, {4'h0, st_v[0], st_m[0], irq, st_raw[0]});
        sel_m = 1'b0;
        step(1);
        chk("view_raw", 8'h01, {7'h00, st_v[0]});
        $display("test mask done");
    endtask : t_mask
    task automatic t_far();
        int k;
        cfg[0].irq = cmpev_pkg::irq_on_rising;
        irq_en[0] = 1'b1;
        auto_clr = 1'b1;
        raw[0] = 1'b0;
        step(4);
        raw[0] = 1'b1;
        step(4);
        chk("far_set", 8'h01, {7'h00, st_raw[0]});
        for (k = 0; k < 8 && st_raw[0] !== 1'b0; k++) step(1);
        if (k == 8) begin
            errors++;
            tally_and_finish();
        end
        chk("far_clr", 8'h00, {7'h00, st_raw[0]});
        $display("test far done");
    endtask : t_far
    initial begin
        step(12);
        rst_b = 1'b1;
        step(1);
        t_ref();
        t_pos();
        t_pin();
        t_trig();
        t_irq();
        t_mask();
        t_far();
        tally_and_finish();
    end
endmodule : tb
bind cmpev_top cmpev_checker u_cmpev_checker (.clk(clk), .rst_b(rst_b), .cfg(cfg),
    .ref_code(ref_code), .irq_enable(irq_enable), .irq_clear(irq_clear),
    .select_masked_status(select_masked_status), .comp_raw(comp_raw), .ref_enable(ref_enable),
    .comp_value(comp_value), .irq_raw_status(irq_raw_status), .irq_out(irq_out),
    .irq_masked_status(irq_masked_status), .irq_status_view(irq_status_view),
    .adc_trigger(adc_trigger));

// *** verilog/cmpev_pkg.sv ***
package cmpev_pkg;
    // Number of comparator units
    localparam int NUM_UNITS = 3;
    // Width of the reference level code
    localparam int REF_CODE_W = 5;
    // Reference code that switches the ladder off
    localparam logic [4:0] REF_CODE_OFF = 5'h00;
    // Highest legal code; codes 01..1C give the 28 levels
    localparam logic [4:0] REF_CODE_MAX = 5'h1C;
    // Synchroniser depth for the asynchronous comparator output
    localparam int SYNC_STAGES = 3;
    // Values after reset
    localparam logic SYNC_RESET = 1'b0;
    localparam logic PEND_RESET = 1'b0;

    // ADC trigger condition select
    typedef enum logic [2:0] {
        adc_trigger_off,
        adc_trigger_on_level_one,
        adc_trigger_on_level_zero,
        adc_trigger_on_falling,
        adc_trigger_on_rising,
        adc_trigger_on_any_edge
    } cmpev_trig_sel_t;

    // Interrupt condition select
    typedef enum logic [2:0] {
        irq_on_level_one,
        irq_on_level_zero,
        irq_on_falling,
        irq_on_rising,
        irq_on_any_edge
    } cmpev_irq_sel_t;

    // Positive input source select
    typedef enum logic [1:0] {
        positive_from_own_pin,
        positive_from_first_unit_pin,
        positive_from_internal_reference
    } cmpev_pos_sel_t;

    // Output pin polarity select
    typedef enum logic [1:0] {
        pin_out_normal,
        pin_out_invert,
        pin_out_legacy_none
    } cmpev_pin_sel_t;

    // Per-unit configuration carried as one bundle
    typedef struct packed {
        cmpev_trig_sel_t trig;
        cmpev_irq_sel_t irq;
        cmpev_pos_sel_t pos;
        cmpev_pin_sel_t pin;
    } cmpev_cfg_t;
endpackage : cmpev_pkg

// *** verilog/cmpev_top.sv ***
`timescale 1ns/1ps
module cmpev_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Per-unit configuration
    input cmpev_pkg::cmpev_cfg_t cfg [cmpev_pkg::NUM_UNITS],
    // Shared reference code
    input wire logic [cmpev_pkg::REF_CODE_W-1:0] ref_code,
    // Interrupt enables and write-one-to-clear strobe
    input wire logic [cmpev_pkg::NUM_UNITS-1:0] irq_enable,
    input wire logic [cmpev_pkg::NUM_UNITS-1:0] irq_clear,
    // Status view select for the status word
    input wire logic select_masked_status,
    // Raw analog comparator outputs, asynchronous
    input wire logic [cmpev_pkg::NUM_UNITS-1:0] comp_raw,
    // Analog steering
    output logic [cmpev_pkg::NUM_UNITS-1:0] use_first_unit_positive_pin,
    output logic [cmpev_pkg::NUM_UNITS-1:0] use_internal_reference,
    output logic ref_enable,
    output logic [cmpev_pkg::REF_CODE_W-1:0] ref_level,
    // Pins and status
    output logic [cmpev_pkg::NUM_UNITS-1:0] comp_pin_out,
    output logic [cmpev_pkg::NUM_UNITS-1:0] comp_value,
    output logic [cmpev_pkg::NUM_UNITS-1:0] irq_raw_status,
    output logic [cmpev_pkg::NUM_UNITS-1:0] irq_masked_status,
    output logic [cmpev_pkg::NUM_UNITS-1:0] irq_status_view,
    output logic irq_out,
    output logic [cmpev_pkg::NUM_UNITS-1:0] adc_trigger
);

    localparam int N = cmpev_pkg::NUM_UNITS;

    // Timing overview, one unit, counted from the edge that first sees a new raw level:
    // Edge 1: first stage takes the raw level, may go metastable
    // Edge 2: second stage takes it, now a clean logic value
    // Edge 3: third stage takes it; second and third now agree
    // After edge 3: settled next level moves, edge events fire combinationally
    // Edge 4: settled level, pin drive, trigger and pending all register together
    // So every registered output shows a raw change four edges after it was driven.
    // A raw pulse shorter than two clocks may be lost entirely.
    // That is the price of filtering comparator chatter near the threshold.
    // Software must not expect to see such narrow glitches in any status.
    //
    // Interrupt and trigger paths share the settled level and the edge events but nothing else.
    // Each has its own select, so one unit may interrupt on a rising edge
    // while the converter is started on the falling edge.
    //
    // Pending bits are sticky in edge modes and follow the condition in level modes.
    // A clear strobe in level mode only drops the bit once the level is gone.
    // In every mode a condition hit in the clear cycle wins over the clear.
    // That avoids losing an edge that lands right as the handler clears.
    //
    // Handshake style outputs are combinational from the pending bits.
    // Data style outputs come straight from flip-flops.
    // The steering and reference outputs are plain decodes of the settings.

    // Synchroniser stages; stage 0 is read only by stage 1
    logic [N-1:0] sync0_reg;
    logic [N-1:0] sync1_reg;
    logic [N-1:0] sync2_reg;
    // Settled level, changes only once stages 1 and 2 agree
    logic [N-1:0] level_reg;
    // Sticky pending bits
    logic [N-1:0] pend_reg;
    logic [N-1:0] pend_next;
    // Registered trigger pulses and pin drive
    logic [N-1:0] trig_reg;
    logic [N-1:0] trig_next;
    logic [N-1:0] pin_reg;
    logic [N-1:0] pin_next;
    // Edge events from the settled level
    logic [N-1:0] rise_evt;
    logic [N-1:0] fall_evt;
    logic [N-1:0] lvl_next;

    // Edge/level condition test used by the interrupt path only
    // Select codes follow the interrupt enum order in the package.
    // Unused codes match nothing, so a bad select can never raise an event.
    // Kept as a function since the decode is reused for every unit.
    function automatic logic cond_hit(input logic [2:0] sel, input logic lvl,
                                      input logic rise, input logic fall);
        case (sel)
            3'h0: cond_hit = lvl;
            3'h1: cond_hit = ~lvl;
            3'h2: cond_hit = fall;
            3'h3: cond_hit = rise;
            3'h4: cond_hit = rise | fall;
            default: cond_hit = 1'b0;
        endcase
    endfunction : cond_hit

    // Three-stage synchroniser on the raw outputs
    // Raw outputs come from analog circuits with no relation to clk.
    // Stage 0 is the only flop that may go metastable.
    // Nothing but stage 1 reads stage 0, so a bad value cannot spread.
    // Reset puts all stages low; a unit whose output idles high
    // therefore reports one rising edge shortly after reset.
    // Software should clear pending bits once after bring-up for that reason.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync0_reg <= {N{cmpev_pkg::SYNC_RESET}};
            sync1_reg <= {N{cmpev_pkg::SYNC_RESET}};
            sync2_reg <= {N{cmpev_pkg::SYNC_RESET}};
        end else begin
            sync0_reg <= comp_raw;
            sync1_reg <= sync0_reg;
            sync2_reg <= sync1_reg;
        end
    end

    // Level moves only when stages 1 and 2 agree
    // Disagreement means a change is still travelling, so the old level holds.
    // Compare is over the whole vector, so a change still travelling in any unit holds every unit's level.
    assign lvl_next = (sync1_reg == sync2_reg) ? sync2_reg : level_reg;
    // Edges are one cycle long since level updates once per change
    assign rise_evt = lvl_next & ~level_reg;
    assign fall_evt = ~lvl_next & level_reg;

    // Settled level register; source of the value read and edge history
    // Keeping one settled copy makes every edge last exactly one cycle.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            level_reg <= {N{cmpev_pkg::SYNC_RESET}};
        end else begin
            level_reg <= lvl_next;
        end
    end

    // Per-unit condition logic
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_unit
            logic irq_hit;
            logic irq_is_level;
            // Interrupt path uses its own select
            assign irq_hit = cond_hit(3'(cfg[g].irq), lvl_next[g], rise_evt[g],
                                      fall_evt[g]);
            assign irq_is_level = (cfg[g].irq == cmpev_pkg::irq_on_level_one) ||
                                  (cfg[g].irq == cmpev_pkg::irq_on_level_zero);

            // Pending: set wins over clear; level keeps it held
            // Order of the branches is the priority:
            // a hit first, then the clear strobe, then level tracking, then hold.
            // Level tracking drops the bit as soon as the level goes away,
            // so a level mode interrupt needs no clear at all to end.
            // Edge modes hold the bit until a clear arrives.
            always_comb begin
                if (irq_hit) begin
                    pend_next[g] = 1'b1;
                end else if (irq_clear[g]) begin
                    pend_next[g] = 1'b0;
                end else if (irq_is_level) begin
                    pend_next[g] = pend_reg[g] & irq_hit;
                end else begin
                    pend_next[g] = pend_reg[g];
                end
            end

            // Trigger path; off selects nothing
            // Level modes hold the trigger for as long as the level stands.
            // Edge modes give one pulse of one clock per transition.
            // The converter side is expected to treat the pulse as a start.
            // Unused codes fall to the default and give no trigger.
            always_comb begin
                case (cfg[g].trig)
                    cmpev_pkg::adc_trigger_off: begin
                        trig_next[g] = 1'b0;
                    end
                    cmpev_pkg::adc_trigger_on_level_one: begin
                        trig_next[g] = lvl_next[g];
                    end
                    cmpev_pkg::adc_trigger_on_level_zero: begin
                        trig_next[g] = ~lvl_next[g];
                    end
                    cmpev_pkg::adc_trigger_on_falling: begin
                        trig_next[g] = fall_evt[g];
                    end
                    cmpev_pkg::adc_trigger_on_rising: begin
                        trig_next[g] = rise_evt[g];
                    end
                    cmpev_pkg::adc_trigger_on_any_edge: begin
                        trig_next[g] = rise_evt[g] | fall_evt[g];
                    end
                    default: begin
                        trig_next[g] = 1'b0;
                    end
                endcase
            end

            // Pin polarity; legacy none acts as normal
            // Only the invert code flips the pin; any other code drives it straight.
            // The pin follows the settled level, so it lags the raw output.
            always_comb begin
                if (cfg[g].pin == cmpev_pkg::pin_out_invert) begin
                    pin_next[g] = ~lvl_next[g];
                end else begin
                    pin_next[g] = lvl_next[g];
                end
            end

            // Positive source steering; unit 0 shared pin is its own pin
            // Unit zero never asserts the shared pin select: its own pin is that pin.
            // Selecting the own pin leaves both steering bits low.
            // The fourth code of the select matches neither choice.
            always_comb begin
                use_internal_reference[g] =
                    (cfg[g].pos == cmpev_pkg::positive_from_internal_reference);
                use_first_unit_positive_pin[g] = (g != 0) &&
                    (cfg[g].pos == cmpev_pkg::positive_from_first_unit_pin);
            end
        end
    endgenerate

    // Registered pending, trigger and pin state
    // One register stage for all three keeps them aligned with the value read.
    // Reset leaves no pending, no trigger and a low pin.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pend_reg <= {N{cmpev_pkg::PEND_RESET}};
            trig_reg <= '0;
            pin_reg <= '0;
        end else begin
            pend_reg <= pend_next;
            trig_reg <= trig_next;
            pin_reg <= pin_next;
        end
    end

    // Reference ladder; codes beyond the top level read as off
    // Code zero is off; codes one to 1C select the levels in rising order.
    // The level index handed to the ladder starts at zero for code one.
    // Treating oversize codes as off avoids an undefined ladder tap.
    always_comb begin
        if (ref_code == cmpev_pkg::REF_CODE_OFF || ref_code > cmpev_pkg::REF_CODE_MAX) begin
            ref_enable = 1'b0;
            ref_level = '0;
        end else begin
            ref_enable = 1'b1;
            ref_level = ref_code - 5'h01;
        end
    end

    // Status and outputs
    // Raw status ignores the enable; masked status is gated by it.
    // The view output picks one of the two by the select input.
    // The interrupt line is the OR of the masked bits only.
    assign comp_value = level_reg;
    assign comp_pin_out = pin_reg;
    assign adc_trigger = trig_reg;
    assign irq_raw_status = pend_reg;
    assign irq_masked_status = pend_reg & irq_enable;
    assign irq_status_view = select_masked_status ? irq_masked_status : irq_raw_status;
    assign irq_out = |irq_masked_status;

endmodule : cmpev_top
